/* kmic_pkg.sv */
// package of constants and types for the keypad mode and indicator control
package kmic_pkg;

    // ********************
    // function groups
    // ********************
    typedef enum logic [3:0] {
        KMIC_GRP_D,
        KMIC_GRP_F,
        KMIC_GRP_A,
        KMIC_GRP_B,
        KMIC_GRP_C,
        KMIC_GRP_H,
        KMIC_GRP_P,
        KMIC_GRP_U,
        KMIC_GRP_E
    } kmic_group_t;

    localparam int KMIC_NUM_GROUPS = 9;
    localparam logic [3:0] KMIC_LAST_GROUP = 4'h8;
    localparam logic [3:0] KMIC_LAST_EDIT_GROUP = 4'h7;

    // ********************
    // parameter store layout
    // ********************
    localparam int KMIC_IDX_W = 5;
    localparam int KMIC_VAL_W = 16;
    localparam int KMIC_NUM_PARAMS = 32;
    localparam logic [KMIC_IDX_W-1:0] KMIC_MAX_IDX = 5'h1F;
    localparam logic [KMIC_VAL_W-1:0] KMIC_MAX_VAL = 16'h270F;
    localparam logic [KMIC_VAL_W-1:0] KMIC_VAL_RESET = 16'h0000;

    // frequency source settings that select the keypad and the potentiometer
    localparam logic [1:0] KMIC_FSRC_KEYPAD = 2'h2;
    localparam logic [1:0] KMIC_FSRC_POT = 2'h0;

    // ********************
    // display units
    // ********************
    typedef enum logic [2:0] {
        KMIC_UNIT_HZ,
        KMIC_UNIT_V,
        KMIC_UNIT_A,
        KMIC_UNIT_KW,
        KMIC_UNIT_PCT,
        KMIC_UNIT_NONE
    } kmic_unit_t;

    // ********************
    // seven-segment patterns, bit order gfedcba, active high
    // ********************
    localparam logic [6:0] KMIC_SEG_BLANK = 7'h00;
    localparam logic [6:0] KMIC_SEG_LO_B = 7'h7C;
    localparam logic [6:0] KMIC_SEG_LO_D = 7'h5E;
    localparam logic [6:0] KMIC_SEG_UP_A = 7'h77;
    localparam logic [6:0] KMIC_SEG_UP_C = 7'h39;
    localparam logic [6:0] KMIC_SEG_UP_E = 7'h79;
    localparam logic [6:0] KMIC_SEG_UP_F = 7'h71;
    localparam logic [6:0] KMIC_SEG_UP_H = 7'h76;
    localparam logic [6:0] KMIC_SEG_UP_P = 7'h73;
    localparam logic [6:0] KMIC_SEG_UP_U = 7'h3E;

    // ********************
    // panel modes
    // ********************
    typedef enum logic [1:0] {
        KMIC_ST_LIST,
        KMIC_ST_VALUE,
        KMIC_ST_ERROR
    } kmic_state_t;

endpackage : kmic_pkg

/* kmic_seg_decode.sv */
// four-digit seven-segment renderer for function codes and values
`timescale 1ns/100ps
`default_nettype none

module kmic_seg_decode
    import kmic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic show_code,
    input wire kmic_group_t group,
    input wire logic [KMIC_IDX_W-1:0] code_idx,
    input wire logic [KMIC_VAL_W-1:0] value,
    output logic [27:0] seg_q
);

    // ********************
    // helpers
    // ********************
    function automatic logic [6:0] kmic_digit(input logic [3:0] d);
        case (d)
            4'h0: kmic_digit = 7'h3F;
            4'h1: kmic_digit = 7'h06;
            4'h2: kmic_digit = 7'h5B;
            4'h3: kmic_digit = 7'h4F;
            4'h4: kmic_digit = 7'h66;
            4'h5: kmic_digit = 7'h6D;
            4'h6: kmic_digit = 7'h7D;
            4'h7: kmic_digit = 7'h07;
            4'h8: kmic_digit = 7'h7F;
            4'h9: kmic_digit = 7'h6F;
            default: kmic_digit = KMIC_SEG_BLANK;
        endcase
    endfunction : kmic_digit

    function automatic logic [6:0] kmic_letter(input kmic_group_t g);
        case (g)
            KMIC_GRP_D: kmic_letter = KMIC_SEG_LO_D; // R20
            KMIC_GRP_B: kmic_letter = KMIC_SEG_LO_B; // R20
            KMIC_GRP_F: kmic_letter = KMIC_SEG_UP_F;
            KMIC_GRP_A: kmic_letter = KMIC_SEG_UP_A;
            KMIC_GRP_C: kmic_letter = KMIC_SEG_UP_C;
            KMIC_GRP_H: kmic_letter = KMIC_SEG_UP_H;
            KMIC_GRP_P: kmic_letter = KMIC_SEG_UP_P;
            KMIC_GRP_U: kmic_letter = KMIC_SEG_UP_U;
            KMIC_GRP_E: kmic_letter = KMIC_SEG_UP_E;
            default: kmic_letter = KMIC_SEG_BLANK;
        endcase
    endfunction : kmic_letter

    // ********************
    // digit split
    // ********************
    logic [15:0] bcd;
    logic [27:0] seg_d;
    logic [KMIC_VAL_W-1:0] num;

    // code numbers are one-based: index 0 shows as 001
    always_comb begin
        num = show_code ? KMIC_VAL_W'(code_idx) + 16'h0001 : value;
        bcd[3:0] = 4'(num % 16'd10);
        bcd[7:4] = 4'((num / 16'd10) % 16'd10);
        bcd[11:8] = 4'((num / 16'd100) % 16'd10);
        bcd[15:12] = 4'((num / 16'd1000) % 16'd10);
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_low
            assign seg_d[gi*7 +: 7] = kmic_digit(bcd[gi*4 +: 4]); // R9
        end
    endgenerate
    assign seg_d[27:21] = show_code ? kmic_letter(group) : kmic_digit(bcd[15:12]); // R16

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            seg_q <= 28'h0000000;
        end else begin
            seg_q <= seg_d;
        end
    end

endmodule : kmic_seg_decode

`default_nettype wire

/* kmic_panel.sv */
// keypad command interpreter, mode tracking and indicator drive
//
// Operation
// [R1] run lamp lit while drive output is active and motor makes torque.
// [R2] program lamp lit in program mode, dark in monitor mode.
// [R3] program lamp also lit while the first monitor function is displayed.
// [R4] keypad frequency source lets up/down change frequency from first monitor.
// [R5] run-enable lamp lit only while the run key is honoured.
// [R6] run key starts motor only when enabled; direction setting picks fwd/rev.
// [R7] stop/reset key decelerates a running motor and clears a tripped alarm.
// [R8] potentiometer-enable lamp lit whenever the potentiometer is a value source.
// [R9] codes and values shown on a four-digit seven-segment display.
// [R10] unit lamp follows monitored value; kilowatts light volt and amp lamps.
// [R11] power lamp lit while input power is present.
// [R12] alarm lamp lit on trip, dark once the alarm is cleared.
// [R13] up/down step through lists, or change the shown value.
// [R14] store key in program mode writes the edited value to nonvolatile memory.
// [R15] last stored parameter is the one shown at power-up.
// [R16] functions coded by group letter plus number, nine groups.
// [R17] monitor group enters monitor mode; editable groups enter program mode.
// [R18] values are edited only in program mode.
// [R19] a fault brings up an error code without any key action.
// [R20] letters b and d rendered in lower case.
// [R21] key edits leave stored values unchanged until store is pressed.
`timescale 1ns/100ps
`default_nettype none

module kmic_panel
    import kmic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_func,
    input wire logic key_store,
    input wire logic key_run,
    input wire logic key_stop,
    input wire logic power_present,
    input wire logic fault_event,
    input wire logic [KMIC_IDX_W-1:0] fault_code,
    input wire logic output_active,
    input wire logic [1:0] frequency_source_select,
    input wire logic run_key_direction_select,
    input wire logic run_source_keypad,
    input wire logic pot_source_other,
    input wire logic [KMIC_VAL_W-1:0] monitor_value,
    input wire kmic_unit_t monitor_unit,
    input wire logic [KMIC_IDX_W-1:0] boot_param_idx,
    input wire kmic_group_t boot_group,
    input wire logic [KMIC_VAL_W-1:0] nv_rd_data,
    output logic nv_wr_en,
    output logic [3:0] nv_wr_group,
    output logic [KMIC_IDX_W-1:0] nv_wr_idx,
    output logic [KMIC_VAL_W-1:0] nv_wr_data,
    output logic [3:0] nv_rd_group,
    output logic [KMIC_IDX_W-1:0] nv_rd_idx,
    output logic [KMIC_VAL_W-1:0] freq_set,
    output logic freq_set_wr,
    output logic run_fwd_cmd,
    output logic run_rev_cmd,
    output logic stop_cmd,
    output logic alarm_clear,
    output logic last_store_wr,
    output logic led_run,
    output logic program_mode_lamp,
    output logic led_run_enable,
    output logic led_pot_enable,
    output logic led_hz,
    output logic led_volt,
    output logic led_amp,
    output logic led_pct,
    output logic led_power,
    output logic led_alarm,
    output logic [27:0] seg_out
);

    // ********************
    // key synchronisers
    // ********************
    localparam int NKEY = 6;
    logic [NKEY-1:0] key_raw;
    logic [NKEY-1:0] key_s1_q;
    logic [NKEY-1:0] key_s2_q;
    logic [NKEY-1:0] key_s3_q;
    logic [NKEY-1:0] key_press;
    logic pwr_s1_q;
    logic pwr_s2_q;
    logic flt_s1_q;
    logic flt_s2_q;
    logic flt_s3_q;

    assign key_raw = {key_stop, key_run, key_store, key_func, key_down, key_up};

    // keys and power come from pins; the first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            key_s1_q <= '0;
            key_s2_q <= '0;
            key_s3_q <= '0;
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
            flt_s1_q <= 1'b0;
            flt_s2_q <= 1'b0;
            flt_s3_q <= 1'b0;
        end else begin
            key_s1_q <= key_raw;
            key_s2_q <= key_s1_q;
            key_s3_q <= key_s2_q;
            pwr_s1_q <= power_present;
            pwr_s2_q <= pwr_s1_q;
            flt_s1_q <= fault_event;
            flt_s2_q <= flt_s1_q;
            flt_s3_q <= flt_s2_q;
        end
    end

    // one press per edge; debounce is left to the key scanner upstream
    assign key_press = key_s2_q & ~key_s3_q;

    logic up_p;
    logic dn_p;
    logic func_p;
    logic str_p;
    logic run_p;
    logic stop_p;
    logic fault_p;
    assign up_p = key_press[0];
    assign dn_p = key_press[1];
    assign func_p = key_press[2];
    assign str_p = key_press[3];
    assign run_p = key_press[4];
    assign stop_p = key_press[5];
    assign fault_p = flt_s2_q & ~flt_s3_q;

    // ********************
    // state
    // ********************
    typedef struct packed {
        kmic_state_t st;
        kmic_group_t grp;
        logic [KMIC_IDX_W-1:0] idx;
        logic [KMIC_VAL_W-1:0] edit;
        logic edited;
        logic booted;
        logic alarm;
        logic running;
        logic nv_wr;
        logic [KMIC_VAL_W-1:0] freq;
        logic freq_wr;
        logic fwd;
        logic rev;
        logic stop;
        logic clr;
        logic last_wr;
    } kmic_regs_t;

    kmic_regs_t r_q;
    kmic_regs_t r_d;

    function automatic logic kmic_is_monitor(input kmic_group_t g);
        kmic_is_monitor = (g == KMIC_GRP_D) || (g == KMIC_GRP_U) || (g == KMIC_GRP_E);
    endfunction : kmic_is_monitor

    logic run_enabled;
    logic first_mon;
    logic in_program;
    logic keypad_freq;

    assign run_enabled = run_source_keypad && !r_q.alarm && !r_q.running;
    assign first_mon = (r_q.grp == KMIC_GRP_D) && (r_q.idx == '0);
    assign in_program = !kmic_is_monitor(r_q.grp) && (r_q.st != KMIC_ST_ERROR); // R17
    assign keypad_freq = frequency_source_select == KMIC_FSRC_KEYPAD;

    always_comb begin
        r_d = r_q;
        r_d.nv_wr = 1'b0;
        r_d.freq_wr = 1'b0;
        r_d.fwd = 1'b0;
        r_d.rev = 1'b0;
        r_d.stop = 1'b0;
        r_d.clr = 1'b0;
        r_d.last_wr = 1'b0;
        // power-up lands on the last stored parameter
        if (!r_q.booted) begin
            r_d.booted = 1'b1;
            r_d.grp = boot_group; // R15
            r_d.idx = boot_param_idx; // R15
        end else begin
            // stop acts in every display state; run in all but the error state, where the alarm blocks it
            if (run_p && run_enabled) begin // R6
                r_d.fwd = !run_key_direction_select; // R6
                r_d.rev = run_key_direction_select; // R6
                r_d.running = 1'b1;
            end
            if (stop_p) begin
                r_d.stop = r_q.running; // R7
                r_d.running = 1'b0;
                if (r_q.alarm) begin
                    r_d.clr = 1'b1; // R7
                    r_d.alarm = 1'b0; // R12
                    if (r_q.st == KMIC_ST_ERROR) begin
                        r_d.st = KMIC_ST_LIST;
                        r_d.grp = KMIC_GRP_D;
                        r_d.idx = '0;
                    end
                end
            end
            case (r_q.st)
                KMIC_ST_LIST: begin
                    if (up_p) begin
                        r_d.idx = (r_q.idx == KMIC_MAX_IDX) ? '0 : r_q.idx + 1'b1; // R13
                    end else if (dn_p) begin
                        r_d.idx = (r_q.idx == '0) ? KMIC_MAX_IDX : r_q.idx - 1'b1; // R13
                    end else if (func_p && r_q.idx == KMIC_MAX_IDX) begin
                        // last entry rolls to the next group, skipping error codes
                        r_d.grp = (r_q.grp >= KMIC_LAST_EDIT_GROUP) ? KMIC_GRP_D
                            : kmic_group_t'(r_q.grp + 1'b1); // R17
                        r_d.idx = '0;
                    end else if (func_p && in_program) begin
                        r_d.st = KMIC_ST_VALUE;
                        r_d.edit = nv_rd_data;
                        r_d.edited = 1'b0;
                    end
                    // frequency nudged straight from the first monitor display
                    if (first_mon && keypad_freq && (up_p || dn_p)) begin // R4
                        r_d.idx = r_q.idx;
                        r_d.freq = up_p ? ((r_q.freq == KMIC_MAX_VAL) ? r_q.freq
                            : r_q.freq + 1'b1) : ((r_q.freq == '0) ? r_q.freq
                            : r_q.freq - 1'b1); // R4
                        r_d.freq_wr = 1'b1; // R4
                    end
                end
                KMIC_ST_VALUE: begin
                    // edits live in a scratch copy until store
                    if (up_p && r_q.edit != KMIC_MAX_VAL) begin
                        r_d.edit = r_q.edit + 1'b1; // R18
                        r_d.edited = 1'b1;
                    end else if (dn_p && r_q.edit != '0) begin
                        r_d.edit = r_q.edit - 1'b1; // R18
                        r_d.edited = 1'b1;
                    end else if (str_p) begin
                        r_d.nv_wr = r_q.edited; // R14 R21
                        r_d.last_wr = r_q.edited; // R15
                        r_d.st = KMIC_ST_LIST;
                    end else if (func_p) begin
                        r_d.st = KMIC_ST_LIST; // R21
                    end
                end
                KMIC_ST_ERROR: begin
                end
                default: r_d.st = KMIC_ST_LIST;
            endcase
            if (fault_p) begin
                r_d.alarm = 1'b1; // R12
                r_d.clr = 1'b0;
                r_d.running = 1'b0;
                r_d.st = KMIC_ST_ERROR; // R19
                r_d.grp = KMIC_GRP_E; // R19
                r_d.idx = fault_code; // R19
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ********************
    // outputs
    // ********************
    assign nv_wr_en = r_q.nv_wr;
    assign nv_wr_group = r_q.grp;
    assign nv_wr_idx = r_q.idx;
    assign nv_wr_data = r_q.edit;
    assign nv_rd_group = r_q.grp;
    assign nv_rd_idx = r_q.idx;
    assign freq_set = r_q.freq;
    assign freq_set_wr = r_q.freq_wr;
    assign run_fwd_cmd = r_q.fwd;
    assign run_rev_cmd = r_q.rev;
    assign stop_cmd = r_q.stop;
    assign alarm_clear = r_q.clr;
    assign last_store_wr = r_q.last_wr;

    logic mon_view;
    assign mon_view = kmic_is_monitor(r_q.grp) && r_q.st == KMIC_ST_LIST;

    // lamps are combinational from registered state and direct inputs
    assign led_run = output_active; // R1
    assign program_mode_lamp = in_program || first_mon; // R2 R3
    assign led_run_enable = run_enabled; // R5
    assign led_pot_enable = (frequency_source_select == KMIC_FSRC_POT) || pot_source_other; // R8
    assign led_hz = mon_view && monitor_unit == KMIC_UNIT_HZ; // R10
    assign led_volt = mon_view && (monitor_unit == KMIC_UNIT_V || monitor_unit == KMIC_UNIT_KW); // R10
    assign led_amp = mon_view && (monitor_unit == KMIC_UNIT_A || monitor_unit == KMIC_UNIT_KW); // R10
    assign led_pct = mon_view && monitor_unit == KMIC_UNIT_PCT; // R10
    assign led_power = pwr_s2_q; // R11
    assign led_alarm = r_q.alarm; // R12

    // ********************
    // display
    // ********************
    logic show_code;
    logic [KMIC_VAL_W-1:0] disp_val;
    // monitor groups d and U show the live value, program groups and E show their code
    assign show_code = (r_q.st != KMIC_ST_VALUE) && !(mon_view && r_q.grp != KMIC_GRP_E);
    assign disp_val = (r_q.st == KMIC_ST_VALUE) ? r_q.edit
        : (first_mon && keypad_freq) ? r_q.freq : monitor_value;

    kmic_seg_decode u_seg (
        .ref_clk(ref_clk),
        .srst(srst),
        .show_code(show_code),
        .group(r_q.grp),
        .code_idx(r_q.idx),
        .value(disp_val),
        .seg_q(seg_out)
    );

endmodule : kmic_panel

`default_nettype wire

/* kmic_panel_chk.sv */
// concurrent checks on the ports of the keypad panel
`timescale 1ns/100ps
`default_nettype none

module kmic_panel_chk
    import kmic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic output_active,
    input wire logic led_run,
    input wire logic power_present,
    input wire logic led_power,
    input wire logic fault_event,
    input wire logic led_alarm,
    input wire logic alarm_clear,
    input wire logic run_fwd_cmd,
    input wire logic run_rev_cmd,
    input wire logic run_key_direction_select,
    input wire logic run_source_keypad,
    input wire logic nv_wr_en,
    input wire logic [3:0] nv_wr_group,
    input wire logic last_store_wr,
    input wire logic [1:0] frequency_source_select,
    input wire logic pot_source_other,
    input wire logic led_pot_enable,
    input wire logic freq_set_wr
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // ********************
    // properties
    // ********************
    property p_run_lamp;
        led_run == output_active;
    endproperty
    a_run_lamp: assert property (p_run_lamp) else $error("run lamp");
    // sync flops add latency
    property p_power_lamp;
        $rose(power_present) |-> ##[1:5] led_power;
    endproperty
    a_power_lamp: assert property (p_power_lamp) else $error("power lamp");
    property p_alarm_set;
        $rose(fault_event) |-> ##[1:6] led_alarm;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm not set");
    property p_alarm_clr;
        alarm_clear |-> !led_alarm;
    endproperty
    a_alarm_clr: assert property (p_alarm_clr) else $error("alarm stays lit");
    property p_run_dir;
        (run_fwd_cmd |-> !run_key_direction_select) and (run_rev_cmd |-> run_key_direction_select);
    endproperty
    a_run_dir: assert property (p_run_dir) else $error("run direction");
    property p_run_src;
        run_fwd_cmd || run_rev_cmd |-> run_source_keypad;
    endproperty
    a_run_src: assert property (p_run_src) else $error("run while disabled");
    property p_run_pulse;
        run_fwd_cmd |=> !run_fwd_cmd;
    endproperty
    a_run_pulse: assert property (p_run_pulse) else $error("run pulse long");
    property p_store_pair;
        nv_wr_en |-> last_store_wr;
    endproperty
    a_store_pair: assert property (p_store_pair) else $error("store unpaired");
    property p_store_prog;
        nv_wr_en |-> nv_wr_group != 4'h0 && nv_wr_group < KMIC_LAST_EDIT_GROUP;
    endproperty
    a_store_prog: assert property (p_store_prog) else $error("store outside program");
    property p_pot_lamp;
        led_pot_enable == (frequency_source_select == KMIC_FSRC_POT || pot_source_other);
    endproperty
    a_pot_lamp: assert property (p_pot_lamp) else $error("pot lamp");
    property p_freq_key;
        freq_set_wr |-> frequency_source_select == KMIC_FSRC_KEYPAD;
    endproperty
    a_freq_key: assert property (p_freq_key) else $error("frequency not keypad");

    c_run: cover property (run_fwd_cmd);
    c_store: cover property (nv_wr_en);
    c_clear: cover property (alarm_clear);
endmodule : kmic_panel_chk

bind kmic_panel kmic_panel_chk kmic_panel_chk_i (.ref_clk, .srst, .output_active, .led_run,
    .power_present, .led_power, .fault_event, .led_alarm, .alarm_clear, .run_fwd_cmd,
    .run_rev_cmd, .run_key_direction_select, .run_source_keypad, .nv_wr_en, .nv_wr_group,
    .last_store_wr, .frequency_source_select, .pot_source_other, .led_pot_enable, .freq_set_wr);

`default_nettype wire

/* kmic_oper_model.sv */
// operator keys and parameter store facing the panel
`timescale 1ns/100ps
`default_nettype none

module kmic_oper_model
    import kmic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nv_wr_en,
    input wire logic [3:0] nv_wr_group,
    input wire logic [KMIC_IDX_W-1:0] nv_wr_idx,
    input wire logic [KMIC_VAL_W-1:0] nv_wr_data,
    input wire logic [3:0] nv_rd_group,
    input wire logic [KMIC_IDX_W-1:0] nv_rd_idx,
    output logic [KMIC_VAL_W-1:0] nv_rd_data,
    output logic [5:0] keys
);
    logic [KMIC_VAL_W-1:0] mem [KMIC_NUM_GROUPS][KMIC_NUM_PARAMS];

    initial begin
        keys = 6'h00;
        for (int g = 0; g < KMIC_NUM_GROUPS; g++) begin
            for (int i = 0; i < KMIC_NUM_PARAMS; i++) begin
                mem[g][i] = 16'h0005;
            end
        end
    end

    // bad group has no cell behind it
    assign nv_rd_data = (nv_rd_group <= KMIC_LAST_GROUP) ? mem[nv_rd_group][nv_rd_idx] : 16'hA5A5;

    always @(posedge ref_clk) begin
        if (nv_wr_en === 1'b1 && nv_wr_group <= KMIC_LAST_GROUP) begin
            mem[nv_wr_group][nv_wr_idx] <= nv_wr_data;
        end
    end

    // held long enough for the three-flop key sync
    task automatic press(input int k);
        keys[k] = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        keys[k] = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask : press
endmodule : kmic_oper_model

`default_nettype wire

/* tb_top.sv */
// self-checking testbench for the keypad panel
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import kmic_pkg::*;
    localparam int K_UP = 0, K_FUNC = 2, K_STORE = 3, K_RUN = 4, K_STOP = 5;
    localparam int WR = 0, LSW = 1, FWD = 2, REV = 3, STP = 4, ACL = 5, FSW = 6;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic power_present = 1'b1;
    logic fault_event = 1'b0;
    logic output_active = 1'b0;
    logic [4:0] fault_code = 5'h03;
    logic [1:0] frequency_source_select = KMIC_FSRC_POT;
    logic run_key_direction_select = 1'b0;
    logic run_source_keypad = 1'b0;
    logic pot_source_other = 1'b0;
    logic [15:0] monitor_value = 16'h0123;
    kmic_unit_t monitor_unit = KMIC_UNIT_HZ;
    logic [4:0] boot_param_idx = 5'h00;
    kmic_group_t boot_group = KMIC_GRP_D;
    logic [15:0] nv_rd_data, nv_wr_data, freq_set;
    logic [3:0] nv_wr_group, nv_rd_group;
    logic [4:0] nv_wr_idx, nv_rd_idx;
    logic nv_wr_en, freq_set_wr, run_fwd_cmd, run_rev_cmd, stop_cmd, alarm_clear, last_store_wr;
    logic led_run, program_mode_lamp, led_run_enable, led_pot_enable, led_hz, led_volt;
    logic led_amp, led_pct, led_power, led_alarm;
    logic [27:0] seg_out;
    logic [5:0] keys;
    logic [6:0] pulses;
    int cnt [7];
    int base [7];
    int fail_count = 0;
    int comparisons = 0;

    always #50 ref_clk = ~ref_clk;

    kmic_oper_model kmic_oper_model_i (.*);
    kmic_panel kmic_panel_i (.key_up(keys[0]), .key_down(keys[1]), .key_func(keys[2]),
        .key_store(keys[3]), .key_run(keys[4]), .key_stop(keys[5]), .*);

    // pulses are counted so no check can miss one
    assign pulses = {freq_set_wr, alarm_clear, stop_cmd, run_rev_cmd, run_fwd_cmd,
        last_store_wr, nv_wr_en};
    always @(posedge ref_clk) begin
        for (int i = 0; i < 7; i++) begin
            cnt[i] += int'(pulses[i] === 1'b1);
        end
    end

    // ********************
    // tasks
    // ********************
    task automatic chk1(input logic got, input logic exp);
        chk16(16'(got), 16'(exp));
    endtask : chk1

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk16

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic snap();
        base = cnt;
    endtask : snap

    task automatic chk_pulse(input int i, input int exp);
        chk16(16'(cnt[i] - base[i]), 16'(exp));
        base[i] = cnt[i];
    endtask : chk_pulse

    task automatic boot(input kmic_group_t g, input logic [4:0] i);
        srst = 1'b1;
        boot_group = g;
        boot_param_idx = i;
        step(8);
        srst = 1'b0;
        step(6);
        snap();
    endtask : boot

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #(20000 * 100);
        fail_count++;
        conclude();
    end

    // ********************
    // tests
    // ********************
    initial begin
        boot(KMIC_GRP_A, 5'h03);
        chk16(16'(nv_rd_group), 16'(KMIC_GRP_A));
        chk16(16'(nv_rd_idx), 16'h0003);
        chk1(program_mode_lamp, 1'b1);
        chk16(16'(seg_out[27:21]), 16'(KMIC_SEG_UP_A));
        chk16(16'(seg_out[6:0]), 16'h0066);
        boot(KMIC_GRP_B, 5'h00);
        chk16(16'(seg_out[27:21]), 16'(KMIC_SEG_LO_B));
        boot(KMIC_GRP_D, 5'h01);
        chk1(program_mode_lamp, 1'b0);
        boot(KMIC_GRP_D, 5'h00);
        chk16(16'(seg_out[6:0]), 16'h0006);
        chk1(program_mode_lamp, 1'b1);
        $display("test display done");
        boot(KMIC_GRP_A, 5'h03);
        kmic_oper_model_i.press(K_FUNC);
        kmic_oper_model_i.press(K_UP);
        chk16(kmic_oper_model_i.mem[2][3], 16'h0005);
        chk_pulse(WR, 0);
        kmic_oper_model_i.press(K_STORE);
        chk_pulse(WR, 1);
        chk_pulse(LSW, 1);
        chk16(kmic_oper_model_i.mem[2][3], 16'h0006);
        kmic_oper_model_i.press(K_UP);
        chk16(16'(nv_rd_idx), 16'h0004);
        boot(KMIC_GRP_D, 5'h01);
        kmic_oper_model_i.press(K_FUNC);
        kmic_oper_model_i.press(K_UP);
        kmic_oper_model_i.press(K_STORE);
        chk_pulse(WR, 0);
        $display("test edit done");
        for (int u = 0; u < 5; u++) begin
            monitor_unit = kmic_unit_t'(u);
            step(2);
            chk1(led_hz, u == 0);
            chk1(led_volt, u == 1 || u == 3);
            chk1(led_amp, u == 2 || u == 3);
            chk1(led_pct, u == 4);
        end
        chk1(led_pot_enable, 1'b1);
        frequency_source_select = KMIC_FSRC_KEYPAD;
        step(1);
        chk1(led_pot_enable, 1'b0);
        power_present = 1'b0;
        step(5);
        chk1(led_power, 1'b0);
        power_present = 1'b1;
        step(5);
        chk1(led_power, 1'b1);
        boot(KMIC_GRP_D, 5'h00);
        kmic_oper_model_i.press(K_UP);
        chk_pulse(FSW, 1);
        chk16(freq_set, 16'h0001);
        $display("test lamps done");
        run_source_keypad = 1'b1;
        step(2);
        chk1(led_run_enable, 1'b1);
        kmic_oper_model_i.press(K_RUN);
        chk_pulse(FWD, 1);
        kmic_oper_model_i.press(K_STOP);
        chk_pulse(STP, 1);
        run_key_direction_select = 1'b1;
        kmic_oper_model_i.press(K_RUN);
        chk_pulse(REV, 1);
        run_source_keypad = 1'b0;
        step(2);
        chk1(led_run_enable, 1'b0);
        kmic_oper_model_i.press(K_RUN);
        chk_pulse(REV, 0);
        output_active = 1'b1;
        step(1);
        chk1(led_run, 1'b1);
        kmic_oper_model_i.press(K_STOP);
        chk_pulse(STP, 1);
        output_active = 1'b0;
        step(1);
        chk1(led_run, 1'b0);
        $display("test run done");
        fault_event = 1'b1;
        step(8);
        chk1(led_alarm, 1'b1);
        chk16(16'(nv_rd_group), 16'(KMIC_GRP_E));
        fault_event = 1'b0;
        step(4);
        snap();
        kmic_oper_model_i.press(K_STOP);
        chk_pulse(ACL, 1);
        chk1(led_alarm, 1'b0);
        $display("test fault done");
        conclude();
    end
endmodule : tb_top

`default_nettype wire
